/* File: bench/clcd_core_sva.sv */
`timescale 1ns/100ps
// -----
// host port and panel checks
// -----
module clcd_core_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host port
  input wire logic register_select,
  input wire logic [7:0] host_wr_data,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_rd_data,
  input wire logic busy_indicator,
  // panel drive
  input wire logic [clcd_pkg::COMMON_CHARS-1:0] common_lines_1_to_32,
  input wire logic icon_line_one,
  input wire logic icon_line_two
);
  import clcd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic is_clear;
  assign is_clear = !register_select && host_wr_data == 8'h01;
  sequence short_busy;
    busy_indicator [*8] ##1 !busy_indicator;
  endsequence
  sequence long_busy;
    busy_indicator [*8] ##120 busy_indicator ##[1:20] !busy_indicator;
  endsequence
  a_busy_short_run: assert property (host_wr && !busy_indicator && !is_clear |=> short_busy)
    else $error("busy run after write wrong");
  a_busy_clear_run: assert property (host_wr && !busy_indicator && is_clear |=> long_busy)
    else $error("busy run after clear wrong");
  a_status_busy_bit: assert property (host_rd && !register_select |=> host_rd_data[7] == $past(busy_indicator))
    else $error("status read busy bit wrong");
  a_rd_data_idle: assert property (!$past(host_rd) |-> host_rd_data == 8'h00)
    else $error("read data outside read cycle");
  a_common_onehot: assert property ($onehot0(common_lines_1_to_32))
    else $error("more than one common selected");
  a_icon_apart: assert property (icon_line_one |-> common_lines_1_to_32 == '0)
    else $error("icon row overlaps common row");
  a_icon_pair: assert property (icon_line_one == icon_line_two)
    else $error("icon lines disagree");
  a_row_hold: assert property ($changed(common_lines_1_to_32) |=> $stable(common_lines_1_to_32) [*8])
    else $error("common row too short");
endmodule

bind clcd_core clcd_core_chk u_chk (.clk(clk), .sys_rst(sys_rst), .register_select(register_select),
  .host_wr_data(host_wr_data), .host_wr(host_wr), .host_rd(host_rd), .host_rd_data(host_rd_data),
  .busy_indicator(busy_indicator), .common_lines_1_to_32(common_lines_1_to_32),
  .icon_line_one(icon_line_one), .icon_line_two(icon_line_two));

/* File: bench/clcd_host_model.sv */
`timescale 1ns/100ps
// -----
// host processor model
// -----
module clcd_host_model (
  // clock
  input wire logic clk,
  // host port
  output logic register_select,
  output logic [7:0] host_wr_data,
  output logic host_wr,
  output logic host_rd,
  input wire logic [7:0] host_rd_data
);
  initial begin
    register_select = 1'b0;
    host_wr_data = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  task automatic wr(input logic rs, input logic [7:0] d);
    @(posedge clk);
    register_select <= rs;
    host_wr_data <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
    host_wr_data <= ~d;
  endtask
  // two writes with no gap
  task automatic wr_pair(input logic rs, input logic [7:0] d0, input logic [7:0] d1);
    @(posedge clk);
    register_select <= rs;
    host_wr_data <= d0;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr_data <= d1;
    @(posedge clk);
    host_wr <= 1'b0;
    host_wr_data <= ~d1;
  endtask
  task automatic rd(input logic rs, output logic [7:0] d);
    @(posedge clk);
    register_select <= rs;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    d = host_rd_data;
  endtask
  // poll status until busy reads low
  task automatic wait_idle(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      rd(1'b0, s);
      ok = !s[7];
    end
  endtask
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import clcd_pkg::*;
  logic clk, sys_rst, register_select, host_wr, host_rd, busy_indicator;
  logic [7:0] host_wr_data, host_rd_data, v;
  logic sel_a, sel_b, place_a, place_b, icon_line_one, icon_line_two;
  logic [COMMON_CHARS-1:0] common_lines_1_to_32;
  logic [SEGMENT_COUNT-1:0] segment_out;
  int err_count, n_tests;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  clcd_core dut (.clk(clk), .sys_rst(sys_rst), .register_select(register_select), .host_wr_data(host_wr_data),
    .host_wr(host_wr), .host_rd(host_rd), .host_rd_data(host_rd_data), .busy_indicator(busy_indicator),
    .glyph_set_select_a(sel_a), .glyph_set_select_b(sel_b), .user_glyph_place_a(place_a),
    .user_glyph_place_b(place_b), .common_lines_1_to_32(common_lines_1_to_32), .icon_line_one(icon_line_one),
    .icon_line_two(icon_line_two), .segment_out(segment_out));
  clcd_host_model host (.clk(clk), .register_select(register_select), .host_wr_data(host_wr_data),
    .host_wr(host_wr), .host_rd(host_rd), .host_rd_data(host_rd_data));
  // -----
  // helpers
  // -----
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic put(input logic rs, input logic [7:0] d);
    logic ok;
    host.wr(rs, d);
    host.wait_idle(ok);
    if (!ok) begin
      err_count++;
      $display("ERROR busy wait expected 0 seen 1");
      summarize();
    end
  endtask
  task automatic wait_row(input logic [31:0] com);
    for (int n = 0; n < 36000 && common_lines_1_to_32 !== com; n++) begin
      @(posedge clk);
      #1;
    end
    chk("common row", com, common_lines_1_to_32);
    if (common_lines_1_to_32 !== com) summarize();
  endtask
  task automatic status(input string nm, input logic [6:0] ac);
    host.rd(1'b0, v);
    chk(nm, {24'h0, 1'b0, ac}, {24'h0, v});
  endtask
  // -----
  // scenarios
  // -----
  task automatic t_panel;
    put(1'b0, 8'h01);
    put(1'b0, 8'h40);
    for (int i = 0; i < 8; i++) put(1'b1, 8'h1F);
    put(1'b0, 8'h80);
    put(1'b1, 8'h00);
    put(1'b0, 8'h0C);
    wait_row(32'h2);
    chk("user glyph row", 32'h1F, {27'h0, segment_out[99:95]});
    chk("icon lines", 32'h0, {30'h0, icon_line_one, icon_line_two});
  endtask
  task automatic t_scan;
    put(1'b0, 8'h1C);
    wait_row(32'h4);
    wait_row(32'h8);
    chk("shifted glyph", 32'h1F, {27'h0, segment_out[94:90]});
    put(1'b0, 8'h80);
    put(1'b0, 8'h31);
    wait_row(32'h10);
    wait_row(32'h20);
    chk("inverted glyph", 32'h0, {27'h0, segment_out[94:90]});
    @(posedge clk);
    place_a <= 1'b1;
    sel_a <= 1'b1;
    sel_b <= 1'b1;
    put(1'b0, 8'h20);
    put(1'b0, 8'h81);
    put(1'b1, 8'h10);
    put(1'b0, 8'hA0);
    put(1'b1, 8'h10);
    wait_row(32'h80);
    chk("moved user glyph", 32'h1F, {27'h0, segment_out[89:85]});
    wait_row(32'h0);
    chk("icon row", 32'h3, {30'h0, icon_line_one, icon_line_two});
    wait_row(32'h1);
    chk("glyph set", 32'h10, {27'h0, segment_out[94:90]});
    put(1'b0, 8'h30);
    wait_row(32'h100);
    chk("second line", 32'h1F, {27'h0, segment_out[94:90]});
  endtask
  task automatic t_write_step;
    put(1'b0, 8'h93);
    put(1'b1, 8'h41);
    status("counter after write", 7'h14);
    put(1'b0, 8'h93);
    host.rd(1'b1, v);
    chk("display byte", 32'h41, {24'h0, v});
    status("counter after read", 7'h14);
  endtask
  task automatic t_refuse;
    logic ok;
    put(1'b0, 8'hA0);
    host.wr_pair(1'b1, 8'h55, 8'hAA);
    host.rd(1'b0, v);
    chk("busy bit", 32'h1, {31'h0, v[7]});
    host.wait_idle(ok);
    status("counter after refused", 7'h21);
    put(1'b0, 8'hA0);
    host.rd(1'b1, v);
    chk("kept byte", 32'h55, {24'h0, v});
  endtask
  task automatic t_decrement;
    put(1'b0, 8'h04);
    put(1'b0, 8'hE0);
    put(1'b1, 8'h11);
    put(1'b1, 8'h22);
    status("counter down", 7'h5E);
    put(1'b0, 8'h80);
    put(1'b1, 8'h33);
    status("counter wrap down", 7'h7F);
    put(1'b0, 8'h06);
    put(1'b0, 8'hFF);
    put(1'b1, 8'h7E);
    status("counter wrap up", 7'h00);
  endtask
  task automatic t_user_mem;
    put(1'b0, 8'h48);
    put(1'b1, 8'h15);
    status("user counter", 7'h09);
    put(1'b0, 8'h48);
    host.rd(1'b1, v);
    chk("user glyph byte", 32'h15, {27'h0, v[4:0]});
  endtask
  initial begin
    err_count = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    sel_a = 1'b0;
    sel_b = 1'b0;
    place_a = 1'b0;
    place_b = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    status("status after reset", 7'h00);
    t_panel();
    t_scan();
    t_write_step();
    t_refuse();
    t_decrement();
    t_user_mem();
    summarize();
  end
endmodule

/* File: hw/clcd_core.sv */
// What this block does
// - busy held during work, instructions refused
// - instruction read shows busy on bit 7
// - display memory holds 128 character codes, eighty shown in four-line mode, twenty in one-line
// - seven bit address counter addresses memory
// - four lines at 00h, 20h, 40h, 60h
// - counter loaded from instruction, selects memory
// - counter steps one after each access
// - instruction read shows counter on bits 0-6
// - cursor, blink and inversion controlled
// - drive 34 commons and 100 segments
// - pattern shifted serially, latched, then driven
// - duty 1/9 one-line, 1/33 four-line
// - fixed glyphs, set chosen by pins
// - eight user glyphs, placement by pins
// - user glyphs shown for matching codes
// - timing generator paces internal operations
`timescale 1ns/100ps
module clcd_core (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host register port
  input wire logic register_select,
  input wire logic [7:0] host_wr_data,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rd_data,
  output logic busy_indicator,
  // option pins
  input wire logic glyph_set_select_a,
  input wire logic glyph_set_select_b,
  input wire logic user_glyph_place_a,
  input wire logic user_glyph_place_b,
  // panel drive
  output logic [clcd_pkg::COMMON_CHARS-1:0] common_lines_1_to_32,
  output logic icon_line_one,
  output logic icon_line_two,
  output logic [clcd_pkg::SEGMENT_COUNT-1:0] segment_out
);
  import clcd_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DISPLAY_DATA_MEMORY_ADDR_BITS-1:0] address_counter;
  logic [DISPLAY_DATA_MEMORY_ADDR_BITS-1:0] next_address_counter;
  clcd_target_type target;
  clcd_target_type next_target;
  logic [3:0] busy_count;
  logic clr_active;
  logic [DISPLAY_DATA_MEMORY_ADDR_BITS-1:0] clr_addr;
  logic entry_up, disp_on, cursor_on, blink_on, four_line, icon_sel, invert_on;
  logic [4:0] shift_pos;
  logic [3:0] pin_meta, pin_sync;
  logic instr_wr, data_wr, data_rd;
  logic [7:0] dd_pre, cg_pre, icon_pre, dd_code, cg_row, icon_row;
  logic dd_we, cg_we, icon_we;
  logic [DISPLAY_DATA_MEMORY_ADDR_BITS-1:0] dd_waddr, dd_scan_addr;
  logic [7:0] dd_wdata;
  clcd_scan_type scan_state;
  logic [5:0] prep_row, duty_rows;
  logic [4:0] scan_pos, rot_pos;
  logic [5:0] pos_sum;
  logic [SEGMENT_COUNT-1:0] seg_shift;
  logic [11:0] row_timer;
  logic row_tick;
  logic [5:0] blink_count;
  logic blink_phase;
  logic is_icon_row, is_user, at_cursor;
  logic [1:0] line_sel;
  logic [4:0] glyph_pat;

  // ---------------------------------------------------------------
  // host decode
  // ---------------------------------------------------------------
  assign instr_wr = host_wr && !register_select && !busy_indicator;
  assign data_wr = host_wr && register_select && !busy_indicator;
  assign data_rd = host_rd && register_select;

  // ---------------------------------------------------------------
  // option pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {user_glyph_place_b, user_glyph_place_a, glyph_set_select_b, glyph_set_select_a};
      pin_sync <= pin_meta;
    end
  end

  // ---------------------------------------------------------------
  // address counter and target
  // ---------------------------------------------------------------
  always_comb begin
    next_address_counter = address_counter;
    next_target = target;
    if (instr_wr) begin
      casez (host_wr_data)
        8'b1???????: begin
          next_address_counter = host_wr_data[6:0];
          next_target = TGT_DISPLAY_DATA_MEMORY;
        end
        8'b01??????: begin
          next_address_counter = {1'b0, host_wr_data[5:0]};
          next_target = icon_sel ? TGT_ICON : TGT_USER_GLYPH_MEMORY;
        end
        8'b0001????: begin
          if (!host_wr_data[SHIFT_DISP_BIT]) begin
            next_address_counter = host_wr_data[SHIFT_RIGHT_BIT] ? address_counter + 7'h01 :
                                   address_counter - 7'h01;
          end
        end
        8'b0000001?, 8'b00000001: begin
          next_address_counter = AC_RESET;
          next_target = TGT_DISPLAY_DATA_MEMORY;
        end
        default: begin
          next_address_counter = address_counter;
        end
      endcase
    end else if (data_wr || data_rd) begin
      next_address_counter = entry_up ? address_counter + 7'h01 : address_counter - 7'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      address_counter <= AC_RESET;
      target <= TGT_DISPLAY_DATA_MEMORY;
    end else begin
      address_counter <= next_address_counter;
      target <= next_target;
    end
  end

  // ---------------------------------------------------------------
  // mode bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      entry_up <= 1'b1;
      disp_on <= 1'b0;
      cursor_on <= 1'b0;
      blink_on <= 1'b0;
      four_line <= 1'b1;
      icon_sel <= 1'b0;
      invert_on <= 1'b0;
      shift_pos <= 5'h00;
    end else if (instr_wr) begin
      casez (host_wr_data)
        8'b000001??: entry_up <= host_wr_data[ENTRY_DIR_BIT];
        8'b00001???: begin
          disp_on <= host_wr_data[DISP_ON_BIT];
          cursor_on <= host_wr_data[CURSOR_ON_BIT];
          blink_on <= host_wr_data[BLINK_ON_BIT];
        end
        8'b0001????: begin
          if (host_wr_data[SHIFT_DISP_BIT] && !host_wr_data[SHIFT_RIGHT_BIT]) begin
            shift_pos <= (shift_pos == LAST_POS) ? 5'h00 : shift_pos + 5'h01;
          end else if (host_wr_data[SHIFT_DISP_BIT]) begin
            shift_pos <= (shift_pos == 5'h00) ? LAST_POS : shift_pos - 5'h01;
          end
        end
        8'b001?????: begin
          four_line <= host_wr_data[FOUR_LINE_BIT];
          icon_sel <= host_wr_data[ICON_SEL_BIT];
          invert_on <= host_wr_data[INVERT_BIT];
        end
        8'b0000001?, 8'b00000001: shift_pos <= 5'h00;
        default: shift_pos <= shift_pos;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // busy and clear sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_active <= 1'b0;
      clr_addr <= 7'h00;
    end else if (instr_wr && host_wr_data == 8'h01) begin
      clr_active <= 1'b1;
      clr_addr <= 7'h00;
    end else if (clr_active) begin
      clr_active <= (clr_addr != 7'h7F);
      clr_addr <= clr_addr + 7'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_count <= 4'h0;
      busy_indicator <= 1'b0;
    end else begin
      if (instr_wr || data_wr) begin
        busy_count <= 4'(INSTR_CYCLES);
      end else if (busy_count != 4'h0 && !clr_active) begin
        busy_count <= busy_count - 4'h1;
      end
      busy_indicator <= instr_wr || data_wr || clr_active || (busy_count > 4'h1);
    end
  end

  // ---------------------------------------------------------------
  // host read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_rd_data <= 8'h00;
    end else if (host_rd && !register_select) begin
      host_rd_data <= {busy_indicator, address_counter};
    end else if (host_rd) begin
      case (target)
        TGT_USER_GLYPH_MEMORY: host_rd_data <= cg_pre;
        TGT_ICON: host_rd_data <= icon_pre;
        default: host_rd_data <= dd_pre;
      endcase
    end else begin
      host_rd_data <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // memories
  // ---------------------------------------------------------------
  assign dd_we = clr_active || (data_wr && target == TGT_DISPLAY_DATA_MEMORY);
  assign dd_waddr = clr_active ? clr_addr : address_counter;
  assign dd_wdata = clr_active ? CLEAR_FILL : host_wr_data;
  assign cg_we = data_wr && target == TGT_USER_GLYPH_MEMORY;
  assign icon_we = data_wr && target == TGT_ICON;

  clcd_mem #(.ADDR_BITS(DISPLAY_DATA_MEMORY_ADDR_BITS), .WIDTH(8)) u_display_data_memory (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(dd_we),
    .wr_addr(dd_waddr),
    .wr_data(dd_wdata),
    .rd_addr_a(next_address_counter),
    .rd_data_a(dd_pre),
    .rd_addr_b(dd_scan_addr),
    .rd_data_b(dd_code)
  );

  clcd_mem #(.ADDR_BITS(USER_GLYPH_MEMORY_ADDR_BITS), .WIDTH(8)) u_user_glyph_memory (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(cg_we),
    .wr_addr(address_counter[USER_GLYPH_MEMORY_ADDR_BITS-1:0]),
    .wr_data(host_wr_data),
    .rd_addr_a(next_address_counter[USER_GLYPH_MEMORY_ADDR_BITS-1:0]),
    .rd_data_a(cg_pre),
    .rd_addr_b({dd_code[2:0], prep_row[2:0]}),
    .rd_data_b(cg_row)
  );

  clcd_mem #(.ADDR_BITS(ICON_ADDR_BITS), .WIDTH(8)) u_icon_pattern_memory (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(icon_we),
    .wr_addr(address_counter[ICON_ADDR_BITS-1:0]),
    .wr_data(host_wr_data),
    .rd_addr_a(next_address_counter[ICON_ADDR_BITS-1:0]),
    .rd_data_a(icon_pre),
    .rd_addr_b(scan_pos[ICON_ADDR_BITS-1:0]),
    .rd_data_b(icon_row)
  );

  // ---------------------------------------------------------------
  // timing generator
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_timer <= 12'h000;
      row_tick <= 1'b0;
      blink_count <= 6'h00;
      blink_phase <= 1'b0;
    end else begin
      row_tick <= (row_timer == 12'(ROW_CYCLES - 1));
      row_timer <= (row_timer == 12'(ROW_CYCLES - 1)) ? 12'h000 : row_timer + 12'h001;
      if (row_tick) begin
        blink_count <= (blink_count == 6'(BLINK_ROWS - 1)) ? 6'h00 : blink_count + 6'h01;
        blink_phase <= (blink_count == 6'(BLINK_ROWS - 1)) ? !blink_phase : blink_phase;
      end
    end
  end

  // ---------------------------------------------------------------
  // glyph fetch
  // ---------------------------------------------------------------
  function automatic logic [4:0] fixed_glyph_row(input logic [7:0] code, input logic [1:0] set,
                                                 input logic [2:0] row);
    logic [1:0] eff_set;
    eff_set = (set == 2'b11) ? 2'b10 : set;
    fixed_glyph_row = (row == CURSOR_ROW) ? 5'h00 : code[4:0] ^ {eff_set, row};
  endfunction

  assign duty_rows = four_line ? DUTY_ROWS_4LINE : DUTY_ROWS_1LINE;
  assign is_icon_row = (prep_row == duty_rows - 6'h01);
  assign line_sel = four_line ? prep_row[4:3] : 2'b00;
  assign pos_sum = {1'b0, scan_pos} + {1'b0, shift_pos};
  assign rot_pos = (pos_sum >= 6'(LINE_CHARS)) ? 5'(pos_sum - 6'(LINE_CHARS)) : pos_sum[4:0];
  assign dd_scan_addr = {line_sel, rot_pos};
  assign is_user = (dd_code[7:3] == {2'b00, pin_sync[3:2], 1'b0});
  assign at_cursor = (target == TGT_DISPLAY_DATA_MEMORY) && (dd_scan_addr == address_counter);

  always_comb begin
    glyph_pat = is_user ? cg_row[4:0] : fixed_glyph_row(dd_code, pin_sync[1:0], prep_row[2:0]);
    if (at_cursor && cursor_on && prep_row[2:0] == CURSOR_ROW) begin
      glyph_pat = 5'h1F;
    end
    if (at_cursor && ((blink_on && blink_phase) || invert_on)) begin
      glyph_pat = ~glyph_pat;
    end
    if (is_icon_row) begin
      glyph_pat = (scan_pos < 5'(ICON_ENTRIES)) ? icon_row[4:0] : 5'h00;
    end
    if (!disp_on) begin
      glyph_pat = 5'h00;
    end
  end

  // ---------------------------------------------------------------
  // scan sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_state <= SCAN_IDLE;
      scan_pos <= 5'h00;
      prep_row <= 6'h00;
      seg_shift <= '0;
    end else if (row_tick) begin
      scan_state <= SCAN_CODE;
      scan_pos <= 5'h00;
      prep_row <= (prep_row >= duty_rows - 6'h01) ? 6'h00 : prep_row + 6'h01;
    end else begin
      case (scan_state)
        SCAN_CODE: scan_state <= SCAN_GLYPH;
        SCAN_GLYPH: scan_state <= SCAN_SHIFT;
        SCAN_SHIFT: begin
          seg_shift <= {seg_shift[SEGMENT_COUNT-DOT_WIDTH-1:0], glyph_pat};
          scan_pos <= scan_pos + 5'h01;
          scan_state <= (scan_pos == LAST_POS) ? SCAN_IDLE : SCAN_CODE;
        end
        default: scan_state <= SCAN_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // segment latch and common select
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      segment_out <= '0;
      common_lines_1_to_32 <= '0;
      icon_line_one <= 1'b0;
      icon_line_two <= 1'b0;
    end else if (row_tick) begin
      segment_out <= seg_shift;
      common_lines_1_to_32 <= is_icon_row ? 32'h00000000 : 32'h00000001 << prep_row[4:0];
      icon_line_one <= is_icon_row;
      icon_line_two <= is_icon_row;
    end
  end

endmodule

/* File: hw/clcd_mem.sv */
`timescale 1ns/100ps
module clcd_mem #(
  parameter int ADDR_BITS = 7,
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // write port
  input wire logic wr_en,
  input wire logic [ADDR_BITS-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // registered read ports
  input wire logic [ADDR_BITS-1:0] rd_addr_a,
  output logic [WIDTH-1:0] rd_data_a,
  input wire logic [ADDR_BITS-1:0] rd_addr_b,
  output logic [WIDTH-1:0] rd_data_b
);

  logic [WIDTH-1:0] mem [2**ADDR_BITS];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule

/* File: hw/clcd_pkg.sv */
package clcd_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int INSTR_TIME_NS = 40;
  localparam int INSTR_CYCLES = (INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TIME_NS = 20000;
  localparam int ROW_CYCLES = ROW_TIME_NS / CLK_PERIOD_NS;
  localparam int BLINK_ROWS = 64;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int DISPLAY_DATA_MEMORY_ADDR_BITS = 7;
  localparam int USER_GLYPH_MEMORY_ADDR_BITS = 6;
  localparam int ICON_ADDR_BITS = 4;
  localparam int ICON_ENTRIES = 16;
  localparam int LINE_CHARS = 20;
  localparam int DOT_WIDTH = 5;
  localparam int COMMON_CHARS = 32;
  localparam int SEGMENT_COUNT = 100;
  localparam logic [5:0] DUTY_ROWS_4LINE = 6'h21;
  localparam logic [5:0] DUTY_ROWS_1LINE = 6'h09;
  localparam logic [4:0] LAST_POS = 5'h13;
  localparam logic [2:0] CURSOR_ROW = 3'h7;

  // ---------------------------------------------------------------
  // instruction fields and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CLEAR_FILL = 8'h20;
  localparam logic [6:0] AC_RESET = 7'h00;
  localparam int ENTRY_DIR_BIT = 1;
  localparam int DISP_ON_BIT = 2;
  localparam int CURSOR_ON_BIT = 1;
  localparam int BLINK_ON_BIT = 0;
  localparam int SHIFT_DISP_BIT = 3;
  localparam int SHIFT_RIGHT_BIT = 2;
  localparam int FOUR_LINE_BIT = 4;
  localparam int ICON_SEL_BIT = 2;
  localparam int INVERT_BIT = 0;

  typedef enum logic [1:0] {
    TGT_DISPLAY_DATA_MEMORY,
    TGT_USER_GLYPH_MEMORY,
    TGT_ICON
  } clcd_target_type;

  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_CODE,
    SCAN_GLYPH,
    SCAN_SHIFT
  } clcd_scan_type;

endpackage
